/* core/rcfg_regs.sv */
`timescale 1ns/100ps
module rcfg_regs
(
    input  wire logic                clock_i,
    input  wire logic                srst_i,
    input  wire logic                sclk_i,
    input  wire logic                sdi_i,
    input  wire logic                cs_n_i,
    input  wire logic [1:0]          band_sel_i,
    input  wire logic signed [7:0]   signal_strength_i,
    input  wire logic                valid_data_indicator_i,
    input  wire logic                cr_locked_i,
    input  wire logic                shared_pin_i,
    output logic                     shared_pin_o,
    output logic                     shared_pin_oe_o,
    output logic                     ext_interrupt_o,
    output logic [11:0]              channel_value_o,
    output logic [21:0]              centre_freq_o,
    output logic                     channel_update_o,
    output logic                     channel_reject_o,
    output logic                     shared_pin_role_o,
    output logic [1:0]               valid_data_speed_o,
    output logic [2:0]               baseband_bandwidth_o,
    output logic [8:0]               bandwidth_khz_o,
    output logic                     bandwidth_reserved_o,
    output logic [1:0]               lna_gain_sel_o,
    output logic signed [7:0]        lna_gain_db_o,
    output logic [2:0]               strength_threshold_sel_o,
    output logic signed [7:0]        threshold_dbm_o,
    output logic                     threshold_reserved_o,
    output logic                     strength_above_o,
    output logic                     auto_lock_enable_o,
    output logic                     manual_lock_speed_o,
    output logic                     cr_fast_mode_o,
    output logic [4:0]               preamble_min_bits_o,
    output logic [4:0]               preamble_max_bits_o,
    output logic                     filter_type_sel_o,
    output logic [2:0]               quality_threshold_o,
    output logic                     filter_word_spare_ok_o
);
    import rcfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic [8:0] bw_khz(input logic [2:0] code);
        case (code)
            3'h1:    bw_khz = 9'h190;
            3'h2:    bw_khz = 9'h154;
            3'h3:    bw_khz = 9'h10e;
            3'h4:    bw_khz = 9'h0c8;
            3'h5:    bw_khz = 9'h086;
            3'h6:    bw_khz = 9'h043;
            default: bw_khz = 9'h000;
        endcase
    endfunction

    function automatic logic signed [7:0] gain_db(input logic [1:0] code);
        case (code)
            2'h1:    gain_db = -8'sd6;
            2'h2:    gain_db = -8'sd14;
            2'h3:    gain_db = -8'sd20;
            default: gain_db = 8'sd0;
        endcase
    endfunction

    // Threshold plus gain magnitude; reserved codes saturate at the top step
    function automatic logic signed [7:0] eff_threshold(input logic [2:0] thr,
                                                        input logic [1:0] gain);
        logic [2:0]        step;
        logic signed [7:0] base;
        step = (thr > 3'h5) ? 3'h5 : thr;
        base = THR_BASE + THR_STEP * $signed({5'h00, step});
        eff_threshold = base - gain_db(gain);
    endfunction

    // Centre frequency in 500 Hz units: mult * (base*20000 + chan*5)
    function automatic logic [21:0] centre_freq(input logic [1:0] band,
                                                input logic [11:0] chan);
        logic [21:0] base;
        logic [21:0] mult;
        logic [21:0] inner;
        base = (band == 2'h3) ? {14'h0000, BAND_HIGH_BASE}
                              : {14'h0000, BAND_LOW_BASE};
        mult = (band == 2'h0) ? 22'h000001 : {20'h00000, band};
        inner = 22'(base * FREQ_BASE_SCALE) + 22'({10'h000, chan} * FREQ_CHAN_SCALE);
        centre_freq = 22'(mult * inner);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial word capture

    rcfg_cmd_if cmd_bus ();

    rcfg_cmd_shift #(
        .WORD_BITS (CMD_WORD_BITS)
    ) u_shift (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .sclk_i  (sclk_i),
        .sdi_i   (sdi_i),
        .cs_n_i  (cs_n_i),
        .cmd     (cmd_bus.source)
    );

    wire [15:0] word = cmd_bus.word;

    wire hit_chan = cmd_bus.valid && (word[15:CMD_CHAN_LSB] == CMD_CHAN);
    wire hit_rx   = cmd_bus.valid && (word[15:CMD_RX_LSB] == CMD_RX);
    wire hit_bbf  = cmd_bus.valid && (word[15:CMD_BBF_LSB] == CMD_BBF);

    wire [11:0] new_chan  = word[CHAN_MSB:0];
    wire        chan_good = (new_chan >= CHAN_MIN) && (new_chan <= CHAN_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // Stored words

    logic [11:0] channel_setting;
    logic [15:0] receiver_control;
    logic [15:0] baseband_filter_control;

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            channel_setting  <= CHAN_RESET[CHAN_MSB:0];
            channel_update_o <= 1'b0;
            channel_reject_o <= 1'b0;
        end
        else
        begin
            channel_update_o <= hit_chan && chan_good;
            channel_reject_o <= hit_chan && !chan_good;
            if (hit_chan && chan_good)
                channel_setting <= new_chan;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            receiver_control <= RX_RESET;
        else if (hit_rx)
            receiver_control <= word;
    end

    // Spare bits 5 and 3 are stored as sent; the host is expected to send ones
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            baseband_filter_control <= BBF_RESET;
        else if (hit_bbf)
            baseband_filter_control <= word;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frequency outputs

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            channel_value_o <= CHAN_RESET[CHAN_MSB:0];
            centre_freq_o   <= 22'h000000;
        end
        else
        begin
            channel_value_o <= channel_setting;
            centre_freq_o   <= centre_freq(band_sel_i, channel_setting);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver fields

    wire [1:0] gain_f = receiver_control[RX_GAIN_LSB +: 2];
    wire [2:0] thr_f  = receiver_control[RX_THR_LSB +: 3];
    wire [2:0] bw_f   = receiver_control[RX_BW_LSB +: 3];

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            shared_pin_role_o        <= RX_RESET[RX_ROLE_BIT];
            valid_data_speed_o       <= RX_RESET[RX_SPEED_LSB +: 2];
            baseband_bandwidth_o     <= RX_RESET[RX_BW_LSB +: 3];
            bandwidth_khz_o          <= 9'h000;
            bandwidth_reserved_o     <= 1'b0;
            lna_gain_sel_o           <= RX_RESET[RX_GAIN_LSB +: 2];
            lna_gain_db_o            <= 8'sh00;
            strength_threshold_sel_o <= RX_RESET[RX_THR_LSB +: 3];
            threshold_dbm_o          <= THR_BASE;
            threshold_reserved_o     <= 1'b0;
        end
        else
        begin
            shared_pin_role_o        <= receiver_control[RX_ROLE_BIT];
            valid_data_speed_o       <= receiver_control[RX_SPEED_LSB +: 2];
            baseband_bandwidth_o     <= bw_f;
            bandwidth_khz_o          <= bw_khz(bw_f);
            bandwidth_reserved_o     <= (bw_f == 3'h0) || (bw_f == 3'h7);
            lna_gain_sel_o           <= gain_f;
            lna_gain_db_o            <= gain_db(gain_f);
            strength_threshold_sel_o <= thr_f;
            threshold_dbm_o          <= eff_threshold(thr_f, gain_f);
            threshold_reserved_o     <= thr_f > 3'h5;
        end
    end

    // Compared against the live threshold, not the delayed output copy
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            strength_above_o <= 1'b0;
        else
            strength_above_o <= signal_strength_i >= eff_threshold(thr_f, gain_f);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared pin: input synchroniser when interrupt role, driver when valid-data

    logic [2:0] pin_s;

    always_ff @(posedge clock_i)
    begin
        pin_s <= {pin_s[1:0], shared_pin_i};
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            shared_pin_o    <= 1'b0;
            shared_pin_oe_o <= 1'b0;
            ext_interrupt_o <= 1'b0;
        end
        else
        begin
            shared_pin_oe_o <= receiver_control[RX_ROLE_BIT];
            shared_pin_o    <= receiver_control[RX_ROLE_BIT] & valid_data_indicator_i;
            if (receiver_control[RX_ROLE_BIT])
                ext_interrupt_o <= 1'b0;
            else if (pin_s[1] == pin_s[2])
                ext_interrupt_o <= pin_s[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baseband filter and clock recovery

    wire auto_f = baseband_filter_control[BBF_AUTO_BIT];
    wire fast_f = baseband_filter_control[BBF_FAST_BIT];

    // Automatic mode overrides the manual bit: fast until locked, then slow
    wire fast_now = auto_f ? !cr_locked_i : fast_f;

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            auto_lock_enable_o     <= BBF_RESET[BBF_AUTO_BIT];
            manual_lock_speed_o    <= BBF_RESET[BBF_FAST_BIT];
            cr_fast_mode_o         <= 1'b0;
            preamble_min_bits_o    <= PRE_SLOW_MIN;
            preamble_max_bits_o    <= PRE_SLOW_MAX;
            filter_type_sel_o      <= BBF_RESET[BBF_TYPE_BIT];
            quality_threshold_o    <= BBF_RESET[BBF_DQ_LSB +: 3];
            filter_word_spare_ok_o <= 1'b1;
        end
        else
        begin
            auto_lock_enable_o     <= auto_f;
            manual_lock_speed_o    <= fast_f;
            cr_fast_mode_o         <= fast_now;
            preamble_min_bits_o    <= fast_now ? PRE_FAST_MIN : PRE_SLOW_MIN;
            preamble_max_bits_o    <= fast_now ? PRE_FAST_MAX : PRE_SLOW_MAX;
            filter_type_sel_o      <= baseband_filter_control[BBF_TYPE_BIT];
            quality_threshold_o    <= baseband_filter_control[BBF_DQ_LSB +: 3];
            // Flags a host that broke the spare-bit convention
            filter_word_spare_ok_o <= baseband_filter_control[BBF_ONE5_BIT]
                                    & baseband_filter_control[BBF_ONE3_BIT];
        end
    end
endmodule

/* core/rcfg_pkg.sv */
package rcfg_pkg;

    localparam int unsigned CMD_WORD_BITS = 16;

    // Command codes, left aligned in the word
    localparam logic [3:0]  CMD_CHAN      = 4'ha;
    localparam int unsigned CMD_CHAN_LSB  = 12;
    localparam logic [4:0]  CMD_RX        = 5'h12;
    localparam int unsigned CMD_RX_LSB    = 11;
    localparam logic [7:0]  CMD_BBF       = 8'hc2;
    localparam int unsigned CMD_BBF_LSB   = 8;

    // Power-on values
    localparam logic [15:0] CHAN_RESET    = 16'ha680;
    localparam logic [15:0] RX_RESET      = 16'h9080;
    localparam logic [15:0] BBF_RESET     = 16'hc22c;

    // Channel word
    localparam int unsigned CHAN_MSB      = 11;
    localparam logic [11:0] CHAN_MIN      = 12'h060;
    localparam logic [11:0] CHAN_MAX      = 12'hf3f;

    // Receiver word fields
    localparam int unsigned RX_ROLE_BIT   = 10;
    localparam int unsigned RX_SPEED_LSB  = 8;
    localparam int unsigned RX_BW_LSB     = 5;
    localparam int unsigned RX_GAIN_LSB   = 3;
    localparam int unsigned RX_THR_LSB    = 0;

    // Filter word fields
    localparam int unsigned BBF_AUTO_BIT  = 7;
    localparam int unsigned BBF_FAST_BIT  = 6;
    localparam int unsigned BBF_ONE5_BIT  = 5;
    localparam int unsigned BBF_TYPE_BIT  = 4;
    localparam int unsigned BBF_ONE3_BIT  = 3;
    localparam int unsigned BBF_DQ_LSB    = 0;

    // Frequency arithmetic, result in 500 Hz units
    localparam logic [21:0] FREQ_BASE_SCALE = 22'h004e20;
    localparam logic [21:0] FREQ_CHAN_SCALE = 22'h000005;
    localparam logic [7:0]  BAND_LOW_BASE   = 8'h2b;
    localparam logic [7:0]  BAND_HIGH_BASE  = 8'h1e;

    // Threshold ladder in dBm
    localparam logic signed [7:0] THR_BASE  = -8'sd103;
    localparam logic signed [7:0] THR_STEP  = 8'sd6;

    // Preamble bits needed per lock speed
    localparam logic [4:0] PRE_FAST_MIN = 5'h06;
    localparam logic [4:0] PRE_FAST_MAX = 5'h08;
    localparam logic [4:0] PRE_SLOW_MIN = 5'h0c;
    localparam logic [4:0] PRE_SLOW_MAX = 5'h10;

    typedef enum logic [1:0] {
        RCFG_ST_IDLE  = 2'b01,
        RCFG_ST_SHIFT = 2'b10
    } rcfg_shift_state_t;

endpackage

/* core/rcfg_cmd_if.sv */
`timescale 1ns/100ps
interface rcfg_cmd_if;
    import rcfg_pkg::*;

    logic [CMD_WORD_BITS-1:0] word;
    logic                     valid;

    modport source (output word, output valid);
    modport sink   (input word, input valid);
endinterface

/* core/rcfg_cmd_shift.sv */
`timescale 1ns/100ps
module rcfg_cmd_shift
#(
    parameter int unsigned WORD_BITS = rcfg_pkg::CMD_WORD_BITS
)
(
    input  wire logic  clock_i,
    input  wire logic  srst_i,
    input  wire logic  sclk_i,
    input  wire logic  sdi_i,
    input  wire logic  cs_n_i,
    rcfg_cmd_if.source cmd
);
    import rcfg_pkg::*;

    if (WORD_BITS != CMD_WORD_BITS)
        $error("rcfg_cmd_shift: WORD_BITS must match the command word");

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage capture; a level counts once stages two and three agree

    logic [2:0] sclk_s;
    logic [2:0] sdi_s;
    logic [2:0] csn_s;
    logic       sclk_f;
    logic       sdi_f;
    logic       csn_f;
    logic       sclk_f_d;

    always_ff @(posedge clock_i)
    begin
        sclk_s <= {sclk_s[1:0], sclk_i};
        sdi_s  <= {sdi_s[1:0], sdi_i};
        csn_s  <= {csn_s[1:0], cs_n_i};
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            sclk_f   <= 1'b0;
            sdi_f    <= 1'b0;
            csn_f    <= 1'b1;
            sclk_f_d <= 1'b0;
        end
        else
        begin
            if (sclk_s[1] == sclk_s[2])
                sclk_f <= sclk_s[2];
            if (sdi_s[1] == sdi_s[2])
                sdi_f <= sdi_s[2];
            if (csn_s[1] == csn_s[2])
                csn_f <= csn_s[2];
            sclk_f_d <= sclk_f;
        end
    end

    wire sclk_rise = sclk_f & ~sclk_f_d;

    ////////////////////////////////////////////////////////////////////////////
    // Word assembly, MSB first; a word cut short by select release is dropped

    rcfg_shift_state_t      state;
    logic [WORD_BITS-1:0]   shreg;
    logic [4:0]             count;

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state     <= RCFG_ST_IDLE;
            shreg     <= '0;
            count     <= 5'h00;
            cmd.word  <= '0;
            cmd.valid <= 1'b0;
        end
        else
        begin
            cmd.valid <= 1'b0;
            case (state)
                RCFG_ST_IDLE:
                begin
                    count <= 5'h00;
                    if (!csn_f)
                        state <= RCFG_ST_SHIFT;
                end
                RCFG_ST_SHIFT:
                begin
                    if (csn_f)
                        state <= RCFG_ST_IDLE;
                    else if (sclk_rise)
                    begin
                        shreg <= {shreg[WORD_BITS-2:0], sdi_f};
                        if (count == 5'(WORD_BITS - 1))
                        begin
                            // Back-to-back words under one select are allowed
                            count     <= 5'h00;
                            cmd.word  <= {shreg[WORD_BITS-2:0], sdi_f};
                            cmd.valid <= 1'b1;
                        end
                        else
                            count <= count + 5'h01;
                    end
                end
                default:
                    state <= RCFG_ST_IDLE;
            endcase
        end
    end
endmodule

/* tb/rcfg_monitor.sv */
`timescale 1ns/100ps
module rcfg_monitor
(
    input wire logic              clock_i,
    input wire logic              srst_i,
    input wire logic signed [7:0] signal_strength_i,
    input wire logic              valid_data_indicator_i,
    input wire logic              cr_locked_i,
    input wire logic              shared_pin_o,
    input wire logic              shared_pin_oe_o,
    input wire logic              shared_pin_role_o,
    input wire logic              ext_interrupt_o,
    input wire logic [11:0]       channel_value_o,
    input wire logic              channel_update_o,
    input wire logic              channel_reject_o,
    input wire logic [2:0]        baseband_bandwidth_o,
    input wire logic [8:0]        bandwidth_khz_o,
    input wire logic              bandwidth_reserved_o,
    input wire logic [1:0]        lna_gain_sel_o,
    input wire logic signed [7:0] lna_gain_db_o,
    input wire logic [2:0]        strength_threshold_sel_o,
    input wire logic signed [7:0] threshold_dbm_o,
    input wire logic              strength_above_o,
    input wire logic              auto_lock_enable_o,
    input wire logic              manual_lock_speed_o,
    input wire logic              cr_fast_mode_o,
    input wire logic [4:0]        preamble_min_bits_o,
    input wire logic [4:0]        preamble_max_bits_o
);
    localparam logic [8:0]        BW_KHZ [8] = '{0, 400, 340, 270, 200, 134, 67, 0};
    localparam logic signed [7:0] GAIN_DB [4] = '{0, -6, -14, -20};

    // Saturating ladder plus gain magnitude
    function automatic logic signed [7:0] thr(input logic [2:0] s, input logic [1:0] g);
        int t;
        t = -103 + 6 * ((s > 3'd5) ? 5 : int'(s)) - int'(GAIN_DB[g]);
        return t[7:0];
    endfunction

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////////
    a_chan_in_range: assert property (channel_value_o >= 96 && channel_value_o <= 3903)
        else $error("stored channel outside accepted range");
    a_chan_change_src: assert property (!$stable(channel_value_o) |-> $past(channel_update_o))
        else $error("channel changed without accepted write");
    a_reject_keeps_chan: assert property (channel_reject_o |-> $stable(channel_value_o)
        ##1 $stable(channel_value_o)) else $error("rejected write changed channel");
    a_role_sets_oe: assert property ($stable(shared_pin_role_o) [*2]
        |-> shared_pin_oe_o == shared_pin_role_o) else $error("pin enable differs from role");
    a_pin_role_out: assert property (shared_pin_role_o [*3]
        |-> shared_pin_o == $past(valid_data_indicator_i) && !ext_interrupt_o)
        else $error("shared pin output wrong in output role");
    a_bw_table: assert property (!$past(srst_i)
        |-> bandwidth_khz_o == BW_KHZ[baseband_bandwidth_o]
        && bandwidth_reserved_o == (BW_KHZ[baseband_bandwidth_o] == 0))
        else $error("bandwidth decode wrong");
    a_gain_table: assert property (!$past(srst_i)
        |-> lna_gain_db_o == GAIN_DB[lna_gain_sel_o]) else $error("gain decode wrong");
    a_thr_sum: assert property (!$past(srst_i)
        |-> threshold_dbm_o == thr(strength_threshold_sel_o, lna_gain_sel_o))
        else $error("threshold decode wrong");
    a_above_cmp: assert property ($stable(threshold_dbm_o) [*2]
        |-> strength_above_o == ($past(signal_strength_i) >= threshold_dbm_o))
        else $error("strength comparison wrong");
    a_fast_select: assert property
        ($stable({auto_lock_enable_o, manual_lock_speed_o, cr_locked_i}) [*2]
        |-> cr_fast_mode_o == (auto_lock_enable_o ? !cr_locked_i : manual_lock_speed_o))
        else $error("lock speed select wrong");
    a_preamble_pair: assert property (preamble_min_bits_o == 6 ? preamble_max_bits_o == 8
        : (preamble_min_bits_o == 12 && preamble_max_bits_o == 16))
        else $error("preamble bounds inconsistent");

    c_update: cover property (channel_update_o);
    c_reject: cover property (channel_reject_o);
    c_pin_out: cover property (shared_pin_role_o && shared_pin_o);
    c_above: cover property ($rose(strength_above_o));
endmodule

bind rcfg_regs rcfg_monitor rcfg_monitor_inst (.*);

/* tb/rcfg_host.sv */
`timescale 1ns/100ps
module rcfg_host
(
    input  wire logic clock_i,
    output logic      sclk_o,
    output logic      sdi_o,
    output logic      cs_n_o
);
    initial {sclk_o, sdi_o, cs_n_o} = 3'b001;

    task automatic start();
        repeat (6) @(negedge clock_i);
        cs_n_o = 1'b0;
        repeat (6) @(negedge clock_i);
    endtask

    task automatic shift(input logic [31:0] w, input int n);
        for (int i = 31; i > 31 - n; i--)
        begin
            sdi_o = w[i];
            repeat (6) @(negedge clock_i);
            sclk_o = 1'b1;
            repeat (6) @(negedge clock_i);
            sclk_o = 1'b0;
        end
    endtask

    // Released data line shows the inverse so a stale bit cannot pass
    task automatic stop();
        repeat (6) @(negedge clock_i);
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
    endtask
endmodule

/* tb/radio_rx_freq_config_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) chk(g, e)
module radio_rx_freq_config_regs_tb;
    import rcfg_pkg::*;
    logic              clock_i, srst_i, sclk, sdi, cs_n, valid_data_indicator, locked, pin_in;
    logic [1:0]        band_sel;
    logic signed [7:0] strength;
    logic              shared_pin_o, shared_pin_oe_o, ext_interrupt_o, channel_update_o;
    logic              channel_reject_o, shared_pin_role_o, bandwidth_reserved_o;
    logic              threshold_reserved_o, strength_above_o, auto_lock_enable_o;
    logic              manual_lock_speed_o, cr_fast_mode_o, filter_type_sel_o;
    logic              filter_word_spare_ok_o;
    logic [11:0]       channel_value_o;
    logic [21:0]       centre_freq_o;
    logic [1:0]        valid_data_speed_o, lna_gain_sel_o;
    logic [2:0]        baseband_bandwidth_o, strength_threshold_sel_o, quality_threshold_o;
    logic [8:0]        bandwidth_khz_o;
    logic signed [7:0] lna_gain_db_o, threshold_dbm_o;
    logic [4:0]        preamble_min_bits_o, preamble_max_bits_o;
    logic [15:0]       rx_m, bbf_m, w;
    int                chan_m, exp_upd, exp_rej, upd_cnt, rej_cnt, n_fail, cmp_count, rnd;
    int                bw_tab [8] = '{0, 400, 340, 270, 200, 134, 67, 0};
    int                gain_tab [4] = '{0, -6, -14, -20};
    int                edge_tab [6] = '{95, 96, 3903, 3904, 4095, 0};

    rcfg_host rcfg_host_inst (.clock_i(clock_i), .sclk_o(sclk), .sdi_o(sdi), .cs_n_o(cs_n));
    rcfg_regs rcfg_regs_inst (.clock_i, .srst_i, .sclk_i(sclk), .sdi_i(sdi), .cs_n_i(cs_n),
        .band_sel_i(band_sel), .signal_strength_i(strength), .valid_data_indicator_i(valid_data_indicator),
        .cr_locked_i(locked), .shared_pin_i(pin_in), .shared_pin_o, .shared_pin_oe_o,
        .ext_interrupt_o, .channel_value_o, .centre_freq_o, .channel_update_o,
        .channel_reject_o, .shared_pin_role_o, .valid_data_speed_o, .baseband_bandwidth_o,
        .bandwidth_khz_o, .bandwidth_reserved_o, .lna_gain_sel_o, .lna_gain_db_o,
        .strength_threshold_sel_o, .threshold_dbm_o, .threshold_reserved_o, .strength_above_o,
        .auto_lock_enable_o, .manual_lock_speed_o, .cr_fast_mode_o, .preamble_min_bits_o,
        .preamble_max_bits_o, .filter_type_sel_o, .quality_threshold_o,
        .filter_word_spare_ok_o);

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Pulses last one cycle, so they are tallied as they pass
    always @(posedge clock_i)
    begin
        if (channel_update_o === 1'b1) upd_cnt++;
        if (channel_reject_o === 1'b1) rej_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic model(input logic [15:0] v);
        if (v[15:12] == CMD_CHAN)
        begin
            if (v[11:0] >= 96 && v[11:0] <= 3903)
            begin
                chan_m = v[11:0];
                exp_upd++;
            end
            else
                exp_rej++;
        end
        else if (v[15:11] == CMD_RX)
            rx_m = v;
        else if (v[15:8] == CMD_BBF)
            bbf_m = v;
    endtask

    task automatic send(input logic [15:0] v, input int n = 16, input logic [15:0] v2 = '0);
        rcfg_host_inst.start();
        rcfg_host_inst.shift({v, v2}, n);
        rcfg_host_inst.stop();
        if (n >= 16) model(v);
        if (n == 32) model(v2);
    endtask

    function automatic int thr_m();
        return -103 + 6 * ((rx_m[2:0] > 5) ? 5 : rx_m[2:0]) - gain_tab[rx_m[4:3]];
    endfunction

    task automatic check_all();
        int b, fast;
        repeat (12) @(negedge clock_i);
        b = (band_sel == 2'd0) ? 1 : band_sel;
        fast = bbf_m[7] ? !locked : bbf_m[6];
        `CHK(channel_value_o, chan_m);
        `CHK(centre_freq_o, b * (((b == 3) ? 30 : 43) * 20000 + chan_m * 5));
        `CHK(upd_cnt, exp_upd);
        `CHK(rej_cnt, exp_rej);
        `CHK({shared_pin_role_o, valid_data_speed_o}, rx_m[10:8]);
        `CHK(baseband_bandwidth_o, rx_m[7:5]);
        `CHK({bandwidth_khz_o, bandwidth_reserved_o}, {9'(bw_tab[rx_m[7:5]]), rx_m[7:5] % 7 == 0});
        `CHK(lna_gain_sel_o, rx_m[4:3]);
        `CHK(lna_gain_db_o, gain_tab[rx_m[4:3]]);
        `CHK({strength_threshold_sel_o, threshold_reserved_o}, {rx_m[2:0], rx_m[2:0] > 5});
        `CHK(threshold_dbm_o, thr_m());
        `CHK({auto_lock_enable_o, manual_lock_speed_o}, bbf_m[7:6]);
        `CHK({filter_type_sel_o, quality_threshold_o}, {bbf_m[4], bbf_m[2:0]});
        `CHK(filter_word_spare_ok_o, bbf_m[5] & bbf_m[3]);
        `CHK(cr_fast_mode_o, fast);
        `CHK({preamble_min_bits_o, preamble_max_bits_o}, fast ? 10'h0c8 : 10'h190);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {srst_i, valid_data_indicator, locked, pin_in, band_sel, strength} = {1'b1, 13'h0};
        {chan_m, rx_m, bbf_m} = {20'h0, CHAN_RESET[11:0], RX_RESET, BBF_RESET};
        {exp_upd, exp_rej, upd_cnt, rej_cnt, n_fail, cmp_count} = '0;
        rnd = $urandom(32'h62e0);
        repeat (10) @(negedge clock_i);
        srst_i = 1'b0;
        check_all();
        for (int b = 0; b < 4; b++)
        begin
            band_sel = b[1:0];
            send({CMD_CHAN, 12'(96 + $urandom_range(3807))});
            check_all();
        end
        foreach (edge_tab[i])
        begin
            send({CMD_CHAN, edge_tab[i][11:0]});
            check_all();
        end
        // Unknown codes, including near misses of real ones
        send(16'h5123);
        send({5'h13, 11'($urandom)});
        send({8'hc3, 8'($urandom)});
        check_all();
        // Select dropped after seven bits
        send({CMD_CHAN, 12'd500}, 7);
        check_all();
        send({CMD_CHAN, 12'd2000}, 32, {CMD_RX, 11'h4a5});
        check_all();
        for (int i = 0; i < 8; i++)
        begin
            w = {CMD_RX, 1'($urandom), i[1:0], i[2:0], i[2:1], 3'(7 - i)};
            send(w);
            check_all();
            valid_data_indicator = 1'($urandom_range(1));
            pin_in = 1'($urandom_range(1));
            strength = 8'(thr_m() - 1 + i[0]);
            repeat (10) @(negedge clock_i);
            `CHK({shared_pin_oe_o, shared_pin_o}, {rx_m[10], rx_m[10] & valid_data_indicator});
            `CHK(ext_interrupt_o, !rx_m[10] & pin_in);
            `CHK(strength_above_o, i[0]);
        end
        for (int i = 0; i < 8; i++)
        begin
            locked = 1'($urandom_range(1));
            send({CMD_BBF, i[1:0], 1'b1, i[2], 1'b1, 3'($urandom_range(3))});
            check_all();
            locked = !locked;
            check_all();
        end
        final_report();
    end

    initial
    begin
        repeat (40000) @(posedge clock_i);
        n_fail++;
        final_report();
    end
endmodule
